// ### verilog/ram_part_pkg.sv
/*
 * Holds the constants and carrier types of the RAM user data partition block.
 * Assumes a 32-bit APB slave clocked by pclk, reset by presetn.
 */
// What this block does
// - Upper sixteen bits unstored, read zero
// - Bits 15-10 writable, non-zero sets user base
// - Bits 9-0 fixed zero, 1 KB steps
// - Reset clears whole register to zero
package ram_part_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] user_data_base_off      = 12'h000; // Partition boundary
    localparam logic [11:0] kernel_program_base_off = 12'h004; // Kernel program base
    localparam logic [11:0] data_ram_size_off       = 12'h008; // RAM size
    localparam logic [11:0] status_off              = 12'h00c; // Partition status

    // ****************************************
    // Field layout and reset values
    // ****************************************
    localparam int          base_lsb        = 10;       // Lowest writable bit
    localparam int          base_msb        = 15;       // Highest writable bit
    localparam logic [5:0]  base_reset      = 6'h00;    // All RAM kernel after reset
    localparam logic [15:0] kprog_reset     = 16'h0000; // Kernel program base at reset
    localparam logic [15:0] ram_size_reset  = 16'h8000; // RAM size at reset, 32 KB

    // Result of a RAM offset lookup
    typedef struct packed {
        logic user;   // Offset is in user data space
        logic kernel; // Offset is in kernel data space
        logic beyond; // Offset is past the RAM size
    } region_t;

endpackage

// ### verilog/ram_region_decode.sv
/*
 * Holds the offset classifier of the RAM partition.
 * Assumes boundary and size come from registers on the same clock.
 */
`timescale 1ns/1ps
module ram_region_decode (
    // Boundary and size
    input  wire logic [15:0]           user_base,
    input  wire logic [15:0]           ram_size,
    // Offset to classify
    input  wire logic [15:0]           offset,
    output ram_part_pkg::region_t      region
);
    import ram_part_pkg::*;

    // ****************************************
    // Classify
    // ****************************************
    // A zero base gives every offset below the RAM size to kernel data
    always_comb begin
        region.beyond = (offset >= ram_size);
        region.user   = !region.beyond && (user_base != 16'h0000) && (offset >= user_base);
        region.kernel = !region.beyond && !region.user;
    end
endmodule

// ### verilog/ram_user_data_partition.sv
/*
 * Holds the APB register file of the RAM user data partition.
 * Assumes an APB master on pclk; ram_offset is a same-clock request.
 */
`timescale 1ns/1ps
module ram_user_data_partition (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // RAM offset lookup
    input  wire logic [15:0]           ram_offset,
    output ram_part_pkg::region_t      ram_region
);
    import ram_part_pkg::*;

    // ****************************************
    // Storage
    // ****************************************
    logic [5:0]  base_field;          // Writable boundary bits
    logic [15:0] kernel_program_base; // Kernel program base copy
    logic [15:0] data_ram_size;       // RAM size
    logic [15:0] user_data_base;      // Full boundary value
    logic        wr_en;               // Write in access phase
    logic        rd_en;               // Read in access phase
    logic        mapped;              // Address decodes
    logic        order_bad;           // Base not above kernel base
    logic        size_bad;            // Base above RAM size
    region_t     next_region;         // Decoder result

    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign mapped  = (paddr == user_data_base_off) || (paddr == kernel_program_base_off) ||
                     (paddr == data_ram_size_off) || (paddr == status_off);
    assign pslverr = psel && penable && !mapped;

    // Boundary, low ten bits fixed zero, top bits absent
    assign user_data_base = {base_field, 10'h000};

    assign order_bad = (user_data_base != 16'h0000) && (user_data_base <= kernel_program_base);
    assign size_bad  = (user_data_base > data_ram_size);

    // ****************************************
    // Boundary register
    // ****************************************
    // Lane 1 carries bits 15-10
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_field <= base_reset;
        end else if (wr_en && paddr == user_data_base_off && pstrb[1]) begin
            base_field <= pwdata[base_msb:base_lsb];
        end
    end

    // ****************************************
    // Kernel program base and RAM size
    // ****************************************
    // Configuration the status flags compare against
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kernel_program_base <= kprog_reset;
        end else if (wr_en && paddr == kernel_program_base_off) begin
            if (pstrb[0]) begin
                kernel_program_base[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                kernel_program_base[15:8] <= pwdata[15:8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_ram_size <= ram_size_reset;
        end else if (wr_en && paddr == data_ram_size_off) begin
            if (pstrb[0]) begin
                data_ram_size[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                data_ram_size[15:8] <= pwdata[15:8];
            end
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Combinational mux; upper half always zero
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                user_data_base_off:      prdata = {16'h0000, user_data_base};
                kernel_program_base_off: prdata = {16'h0000, kernel_program_base};
                data_ram_size_off:       prdata = {16'h0000, data_ram_size};
                status_off:              prdata = {29'h0, size_bad, order_bad, (base_field != 6'h00)};
                default:                 prdata = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Region lookup
    // ****************************************
    ram_region_decode u_decode (
        .user_base (user_data_base),
        .ram_size  (data_ram_size),
        .offset    (ram_offset),
        .region    (next_region)
    );

    // Registered so the region output comes from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_region <= '0;
        end else begin
            ram_region <= next_region;
        end
    end
endmodule

// ### tb/ram_part_asserts.sv
/* Checker for the RAM partition register block.
   Assumes binding onto the top module's ports. */
`timescale 1ns/1ps
module ram_part_asserts
    import ram_part_pkg::*;
(
    input wire logic          pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0]   paddr,
    input wire logic [31:0]   pwdata, prdata,
    input wire logic [3:0]    pstrb,
    input wire logic [15:0]   ram_offset,
    input wire ram_part_pkg::region_t ram_region
);
    // Read of the boundary word in its access phase
    wire logic rd0 = psel && penable && !pwrite && paddr == user_data_base_off;
    logic [5:0] ub; // Shadow of the boundary field
    // Follows accepted writes with lane 1 enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ub <= 6'h00;
        end else if (psel && penable && pwrite && paddr == user_data_base_off && pstrb[1]) begin
            ub <= pwdata[15:10];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    hi_zero_a: assert property (rd0 |-> prdata[31:16] == 16'h0000) else $error("upper half set");
    field_rd_a: assert property (rd0 |-> prdata[15:10] == ub) else $error("boundary field wrong");
    lo_zero_a: assert property (rd0 |-> prdata[9:0] == 10'h000) else $error("low bits set");
    reset_clear_a: assert property ($rose(presetn) |-> ram_region == 3'h0) else $error("region not cleared");
    user_side_a: assert property (ram_region.user |-> $past(ub) != 6'h00
        && $past(ram_offset) >= {$past(ub), 10'h000}) else $error("user below boundary");
    kernel_side_a: assert property (ram_region.kernel |-> $past(ub) == 6'h00
        || $past(ram_offset) < {$past(ub), 10'h000}) else $error("kernel above boundary");
    cover property (rd0 && prdata[15:10] != 6'h00);
    cover property (ram_region.user);
    cover property (ram_region.beyond);
endmodule
bind ram_user_data_partition ram_part_asserts u_ram_part_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pstrb(pstrb), .ram_offset(ram_offset), .ram_region(ram_region));

// ### tb/ram_user_data_partition_tb_top.sv
/* Self-checking bench of the RAM partition block.
   Assumes the package and design files are compiled first. */
`timescale 1ns/1ps
module ram_user_data_partition_tb_top;
    import ram_part_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, d;
    logic [3:0]  pstrb = 4'h0;
    logic [15:0] ram_offset = 16'h0;
    region_t     ram_region;
    int          fail_count = 0, n_tests = 0, cyc = 0, base = 0, b, size = 32'h8000;
    always #2.5 pclk = ~pclk;
    ram_user_data_partition u_ram_user_data_partition (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ram_offset(ram_offset), .ram_region(ram_region));
    // Cuts a hang short
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            summarize();
        end
    end
    task summarize;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; holds the request until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] s,
             output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Classifies one offset against the model
    task look(input logic [15:0] off);
        logic u, k, x;
        @(posedge pclk);
        ram_offset <= off;
        @(posedge pclk);
        #1;
        x = off >= size;
        u = !x && base != 0 && off >= base * 1024;
        k = !x && !u;
        cmp({29'h0, ram_region}, {29'h0, u, k, x});
    endtask
    initial begin
        rd = $urandom(32'hfee4);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, user_data_base_off, 32'h0, 4'h0, rd);
        cmp(rd, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            b = $urandom_range(32, 1);
            d = $urandom;
            d[15:10] = b[5:0];
            apb(1'b1, user_data_base_off, d, (i == 3) ? 4'h1 : 4'hf, rd);
            if (i != 3) base = b;
            apb(1'b0, user_data_base_off, 32'h0, 4'h0, rd);
            cmp(rd, 32'(base << 10));
            repeat (4) look(16'($urandom_range(32'h8fff, 0)));
        end
        $display("test boundary done");
        apb(1'b1, kernel_program_base_off, 32'h0000_0400, 4'hf, rd);
        apb(1'b0, kernel_program_base_off, 32'h0, 4'h0, rd);
        cmp(rd, 32'h0000_0400);
        apb(1'b0, status_off, 32'h0, 4'h0, rd);
        cmp(rd, {29'h0, base * 1024 > size, base * 1024 <= 32'h400, 1'b1});
        apb(1'b0, 12'h010, 32'h0, 4'h0, rd);
        cmp({31'h0, err}, 32'h1);
        cmp(rd, 32'h0);
        apb(1'b1, 12'h010, 32'hffff_ffff, 4'hf, rd);
        apb(1'b0, user_data_base_off, 32'h0, 4'h0, rd);
        cmp(rd, 32'(base << 10));
        cmp({31'h0, err}, 32'h0);
        $display("test config done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        base = 0;
        apb(1'b0, user_data_base_off, 32'h0, 4'h0, rd);
        cmp(rd, 32'h0);
        look(16'h7c00);
        $display("test second reset done");
        summarize();
    end
endmodule
